// ===== inc/bfl_params.svh
`ifndef BFL_PARAMS_SVH
`define BFL_PARAMS_SVH

// register byte addresses on the apb bus
`define BFL_ADDR_CTRL      12'h000
`define BFL_ADDR_LOCK      12'h004
`define BFL_ADDR_STATUS    12'h008
`define BFL_ADDR_CORE      12'h00C

// self_program_control field positions
`define BFL_BIT_IRQ_EN     7
`define BFL_BIT_BUSY       6
`define BFL_BIT_REENABLE   4
`define BFL_BIT_LOCKSET    3
`define BFL_BIT_PGWRITE    2
`define BFL_BIT_PGERASE    1
`define BFL_BIT_STORE_EN   0
`define BFL_CTRL_RESET     8'h00

// accepted lower five bit write patterns
`define BFL_PAT_REENABLE   5'h11
`define BFL_PAT_LOCKSET    5'h09
`define BFL_PAT_PGWRITE    5'h05
`define BFL_PAT_PGERASE    5'h03
`define BFL_PAT_FILL       5'h01

// lock field reset: unprogrammed
`define BFL_LOCK_RESET     2'h3
`define BFL_APP_RESET_VEC  16'h0000
`define BFL_BLOCKED_DATA   16'hFFFF

// store window: four clock cycles
`define BFL_STORE_WIN_CYC  3'h4
// program operation length in cycles
`define BFL_PROG_CYC       16'h0100

`endif

// ===== inc/bfl_pkg.sv
package bfl_pkg;
  typedef enum logic [2:0] {
    BFL_CMD_NONE,
    BFL_CMD_FILL,
    BFL_CMD_ERASE,
    BFL_CMD_WRITE,
    BFL_CMD_LOCKSET,
    BFL_CMD_REENABLE
  } bfl_cmd_t;
  typedef enum logic [1:0] {
    BFL_ST_IDLE,
    BFL_ST_ARMED,
    BFL_ST_PROG
  } bfl_state_t;
endpackage

// ===== inc/bfl_lock_if.sv
`timescale 1ns/1ps
interface bfl_lock_if;
  logic [1:0] app_lock_field;
  logic [1:0] boot_lock_field;
  logic [15:0] addr;
  logic       exec_in_boot;
  logic       ivec_in_boot;
  logic       busy;
  logic       addr_is_boot;
  logic       addr_is_rww;
  logic       store_ok;
  logic       load_ok;
  logic       irq_block;
  modport ckr (input app_lock_field, boot_lock_field, addr, exec_in_boot, ivec_in_boot,
               busy, output addr_is_boot, addr_is_rww, store_ok, load_ok, irq_block);
  modport ctl (output app_lock_field, boot_lock_field, addr, exec_in_boot, ivec_in_boot,
               busy, input addr_is_boot, addr_is_rww, store_ok, load_ok, irq_block);
endinterface

// ===== rtl/bfl_lock_check.sv
`timescale 1ns/1ps
`include "bfl_params.svh"
module bfl_lock_check #(
  parameter int AW = 16
) (
  // section boundaries from boot size fuses
  input  wire logic [AW-1:0] boot_start_in,
  input  wire logic [AW-1:0] rww_end_in,
  // lock checker channel
  bfl_lock_if.ckr            lk
);
  // section decode by fuse boundaries
  assign lk.addr_is_boot = (lk.addr >= boot_start_in); // [RULE25]
  assign lk.addr_is_rww  = (lk.addr < rww_end_in);

  wire app_write_blk  = ~lk.app_lock_field[0];   // modes 2,3 [RULE5]
  wire app_read_blk   = ~lk.app_lock_field[1];   // modes 3,4 [RULE6]
  wire boot_write_blk = ~lk.boot_lock_field[0];  // [RULE9]
  wire boot_read_blk  = ~lk.boot_lock_field[1];  // [RULE10]
  wire rww_blk        = lk.busy & lk.addr_is_rww; // [RULE16]

  // general lock modes are not inputs here at all [RULE2] [RULE3]
  // unprogrammed fields leave the access open [RULE4] [RULE8]
  assign lk.store_ok = ~rww_blk &
    (lk.addr_is_boot ? ~boot_write_blk : ~app_write_blk);
  // a read lock only blocks a load crossing into the other section; busy blocks any rww load
  assign lk.load_ok = ~rww_blk &
    (lk.addr_is_boot ? ~(boot_read_blk & ~lk.exec_in_boot)
                     : ~(app_read_blk & lk.exec_in_boot));
  // interrupts masked when code runs in a read-locked section and the vectors sit in the other section
  assign lk.irq_block =
    (app_read_blk & lk.ivec_in_boot & ~lk.exec_in_boot) |    // [RULE7]
    (boot_read_blk & ~lk.ivec_in_boot & lk.exec_in_boot);    // [RULE11]
endmodule

// ===== rtl/bfl_boot_lock_ctrl.sv
`timescale 1ns/1ps
`include "bfl_params.svh"
// Function
// RULE1 - lock bits only program from software; only chip erase unprograms them (reset here also restores both lock fields to unprogrammed)
// RULE2 - general write lock does not gate store instructions
// RULE3 - general read/write lock does not gate core load or store
// RULE4 - application locks unprogrammed: full access to application section
// RULE5 - application write lock bit programmed blocks stores into application
// RULE6 - application read lock blocks boot-executed loads of application data
// RULE7 - application read lock masks interrupts when vectors in boot section
// RULE8 - boot locks unprogrammed: full access to boot loader section
// RULE9 - boot write lock bit programmed blocks stores into boot section
// RULE10 - boot read lock blocks application-executed loads of boot data
// RULE11 - boot read lock masks interrupts in boot when vectors in application
// RULE12 - reset vector is zero or boot start by boot reset fuse
// RULE13 - core has no path to change any fuse
// RULE14 - control register resets zero, bit5 reads zero, busy read-only
// RULE15 - ready interrupt requested while enabled, global flag set, store idle
// RULE16 - program of concurrent section sets busy and blocks that section
// RULE17 - busy clears by re-enable after completion or on buffer fill
// RULE18 - re-enable plus store enable arms; store within four cycles reopens
// RULE19 - re-enable ignored while erase or write still runs
// RULE20 - re-enable during buffer loading discards loaded data
// RULE21 - store enable opens four-cycle window, auto-clears on completion
// RULE22 - only five listed lower-bit patterns take effect
// RULE23 - program of stalling section halts core for whole operation
// RULE24 - page buffer erases after page write, re-enable and reset
// RULE25 - section chosen by comparing address to fuse-supplied boundary
// RULE26 - blocked store changes nothing; blocked load returns all ones
module bfl_boot_lock_ctrl #(
  parameter int          AW        = 16,
  parameter logic [15:0] PROG_CYC  = `BFL_PROG_CYC,
  parameter logic [15:0] BLOCK_VAL = `BFL_BLOCKED_DATA
) (
  // clock and reset
  input  wire logic          MCLK_IN,
  input  wire logic          RESETN_IN,
  // apb slave
  input  wire logic          PSEL_IN,
  input  wire logic          PENABLE_IN,
  input  wire logic          PWRITE_IN,
  input  wire logic [11:0]   PADDR_IN,
  input  wire logic [31:0]   PWDATA_IN,
  output logic      [31:0]   PRDATA_OUT,
  output logic               PREADY_OUT,
  output logic               PSLVERR_OUT,
  // core instruction side
  input  wire logic          STORE_REQ_IN,
  input  wire logic          LOAD_REQ_IN,
  input  wire logic [AW-1:0] FLASH_ADDR_IN,
  input  wire logic [15:0]   FLASH_RDATA_IN,
  input  wire logic [7:0]    LOCK_WDATA_IN,
  input  wire logic          EXEC_IN_BOOT_IN,
  input  wire logic          IVEC_IN_BOOT_IN,
  input  wire logic          GLOBAL_IRQ_EN_IN,
  output logic      [15:0]   LOAD_DATA_OUT,
  output logic               LOAD_BLOCKED_OUT,
  output logic               STORE_BLOCKED_OUT,
  output logic               IRQ_BLOCK_OUT,
  output logic               READY_IRQ_OUT,
  output logic               CORE_HALT_OUT,
  // flash array side
  output logic               FLASH_ERASE_OUT,
  output logic               FLASH_WRITE_OUT,
  output logic               BUF_FILL_OUT,
  output logic               BUF_CLEAR_OUT,
  output logic      [AW-1:0] FLASH_PAGE_ADDR_OUT,
  // fuses and chip erase from external programming
  input  wire logic          CHIP_ERASE_IN,
  input  wire logic          BOOT_RESET_FUSE_IN,
  input  wire logic [AW-1:0] BOOT_START_IN,
  input  wire logic [AW-1:0] RWW_END_IN,
  output logic      [AW-1:0] RESET_VECTOR_OUT
);
  logic [7:0]       ctrl_reg, ctrl_next;
  logic [1:0]       app_lock_reg, boot_lock_reg;
  logic [2:0]       win_reg;
  logic [15:0]      prog_cnt_reg;
  logic             busy_reg, loading_reg, halt_reg;
  logic [AW-1:0]    page_reg;
  logic [15:0]      load_data_reg;
  logic             load_blk_reg, store_blk_reg;
  bfl_pkg::bfl_state_t state_reg;
  bfl_lock_if       lk ();

  function automatic bfl_pkg::bfl_cmd_t decode_cmd(input logic [4:0] pat);
    if (pat == `BFL_PAT_FILL)          decode_cmd = bfl_pkg::BFL_CMD_FILL;
    else if (pat == `BFL_PAT_PGERASE)  decode_cmd = bfl_pkg::BFL_CMD_ERASE;
    else if (pat == `BFL_PAT_PGWRITE)  decode_cmd = bfl_pkg::BFL_CMD_WRITE;
    else if (pat == `BFL_PAT_LOCKSET)  decode_cmd = bfl_pkg::BFL_CMD_LOCKSET;
    else if (pat == `BFL_PAT_REENABLE) decode_cmd = bfl_pkg::BFL_CMD_REENABLE;
    else                               decode_cmd = bfl_pkg::BFL_CMD_NONE;
  endfunction

  // lock checker connection
  assign lk.app_lock_field  = app_lock_reg;
  assign lk.boot_lock_field = boot_lock_reg;
  assign lk.addr            = FLASH_ADDR_IN;
  assign lk.exec_in_boot    = EXEC_IN_BOOT_IN;
  assign lk.ivec_in_boot    = IVEC_IN_BOOT_IN;
  assign lk.busy            = busy_reg;

  bfl_lock_check #(.AW(AW)) u_check (
    .boot_start_in (BOOT_START_IN),
    .rww_end_in    (RWW_END_IN),
    .lk            (lk)
  );

  // apb decode, zero wait states
  wire apb_acc  = PSEL_IN & PENABLE_IN;
  wire apb_wr   = apb_acc & PWRITE_IN;
  wire hit_ctrl = (PADDR_IN == `BFL_ADDR_CTRL);
  wire hit_lock = (PADDR_IN == `BFL_ADDR_LOCK);
  wire hit_stat = (PADDR_IN == `BFL_ADDR_STATUS);
  wire hit_core = (PADDR_IN == `BFL_ADDR_CORE);
  wire hit_any  = hit_ctrl | hit_lock | hit_stat | hit_core;
  wire ctrl_wr  = apb_wr & hit_ctrl;
  // command writes only land when no erase or write operation is running
  wire op_busy  = (state_reg == bfl_pkg::BFL_ST_PROG);
  bfl_pkg::bfl_cmd_t wr_cmd;
  assign wr_cmd = decode_cmd(PWDATA_IN[4:0]);
  // reenable attempts during a running program are dropped
  wire cmd_ok   = ctrl_wr & (wr_cmd != bfl_pkg::BFL_CMD_NONE) & ~op_busy;   // [RULE22] [RULE19]
  wire armed    = (state_reg == bfl_pkg::BFL_ST_ARMED);
  wire store_go = armed & STORE_REQ_IN;
  wire store_ok = lk.store_ok;
  bfl_pkg::bfl_cmd_t cur_cmd;
  assign cur_cmd = decode_cmd(ctrl_reg[4:0]);
  wire is_prog  = (cur_cmd == bfl_pkg::BFL_CMD_ERASE) | (cur_cmd == bfl_pkg::BFL_CMD_WRITE);
  wire is_reen  = (cur_cmd == bfl_pkg::BFL_CMD_REENABLE);
  wire is_fill  = (cur_cmd == bfl_pkg::BFL_CMD_FILL);
  wire is_lset  = (cur_cmd == bfl_pkg::BFL_CMD_LOCKSET);
  // blocked stores do nothing to flash or buffer
  wire do_prog  = store_go & is_prog & store_ok;                  // [RULE26]
  wire do_fill  = store_go & is_fill & store_ok;
  wire prog_end = op_busy & (prog_cnt_reg == 16'h0001);
  wire win_end  = armed & (win_reg == 3'h1) & ~STORE_REQ_IN;
  // re-enable write discards a buffer being loaded
  wire reen_wr  = cmd_ok & (wr_cmd == bfl_pkg::BFL_CMD_REENABLE);  // [RULE20]

  // control register next value
  always_comb begin
    ctrl_next = ctrl_reg;
    if (ctrl_wr) begin
      ctrl_next[`BFL_BIT_IRQ_EN] = PWDATA_IN[`BFL_BIT_IRQ_EN];
    end
    if (cmd_ok) begin
      ctrl_next[4:0] = PWDATA_IN[4:0];
    end else if ((store_go & ~is_prog) | win_end | prog_end | (store_go & ~store_ok)) begin
      ctrl_next[4:0] = 5'h00; // auto-clear [RULE21]
    end
    ctrl_next[`BFL_BIT_BUSY] = 1'b0;
    ctrl_next[5]             = 1'b0; // reserved [RULE14]
  end

  // control register and store window
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      ctrl_reg     <= `BFL_CTRL_RESET; // [RULE14]
      state_reg    <= bfl_pkg::BFL_ST_IDLE;
      win_reg      <= 3'h0;
      prog_cnt_reg <= 16'h0000;
      page_reg     <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      case (state_reg)
        bfl_pkg::BFL_ST_IDLE: begin
          if (cmd_ok) begin
            state_reg <= bfl_pkg::BFL_ST_ARMED;
            win_reg   <= `BFL_STORE_WIN_CYC; // [RULE18] [RULE21]
          end
        end
        bfl_pkg::BFL_ST_ARMED: begin
          if (do_prog) begin
            state_reg    <= bfl_pkg::BFL_ST_PROG;
            prog_cnt_reg <= PROG_CYC;
            page_reg     <= FLASH_ADDR_IN;
          end else if (store_go | win_end) begin
            state_reg <= bfl_pkg::BFL_ST_IDLE;
          end else begin
            win_reg <= win_reg - 3'h1;
          end
        end
        bfl_pkg::BFL_ST_PROG: begin
          prog_cnt_reg <= prog_cnt_reg - 16'h0001;
          if (prog_end) begin
            state_reg <= bfl_pkg::BFL_ST_IDLE;
          end
        end
        default: state_reg <= bfl_pkg::BFL_ST_IDLE;
      endcase
    end
  end

  // busy flag: set wins over any clear
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      busy_reg <= 1'b0;
    end else if (do_prog & lk.addr_is_rww) begin
      busy_reg <= 1'b1; // [RULE16]
    end else if ((store_go & is_reen) | do_fill) begin
      busy_reg <= 1'b0; // [RULE17] [RULE18]
    end
  end

  // core halt for the stalling section
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      halt_reg <= 1'b0;
    end else if (do_prog & ~lk.addr_is_rww) begin
      halt_reg <= 1'b1; // [RULE23]
    end else if (prog_end) begin
      halt_reg <= 1'b0;
    end
  end

  // buffer loading tracking
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      loading_reg <= 1'b0;
    end else if (do_fill) begin
      loading_reg <= 1'b1;
    end else if (reen_wr | (do_prog & (cur_cmd == bfl_pkg::BFL_CMD_WRITE))) begin
      loading_reg <= 1'b0;
    end
  end

  // lock bits: software may only program (clear) bits, chip erase restores
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      app_lock_reg  <= `BFL_LOCK_RESET;
      boot_lock_reg <= `BFL_LOCK_RESET;
    end else if (CHIP_ERASE_IN) begin
      app_lock_reg  <= `BFL_LOCK_RESET; // [RULE1]
      boot_lock_reg <= `BFL_LOCK_RESET;
    end else if (store_go & is_lset) begin
      app_lock_reg  <= app_lock_reg & LOCK_WDATA_IN[3:2];  // [RULE1]
      boot_lock_reg <= boot_lock_reg & LOCK_WDATA_IN[5:4];
    end
  end

  // load path and block indications
  always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      load_data_reg <= 16'h0000;
      load_blk_reg  <= 1'b0;
      store_blk_reg <= 1'b0;
    end else begin
      store_blk_reg <= store_go & ~is_lset & ~is_reen & ~store_ok;
      if (LOAD_REQ_IN) begin
        load_blk_reg  <= ~lk.load_ok;
        load_data_reg <= lk.load_ok ? FLASH_RDATA_IN : BLOCK_VAL; // [RULE26]
      end
    end
  end

  // flash strobes; write/reenable clear buffer, reset clears it too
  assign FLASH_ERASE_OUT     = do_prog & (cur_cmd == bfl_pkg::BFL_CMD_ERASE);
  assign FLASH_WRITE_OUT     = do_prog & (cur_cmd == bfl_pkg::BFL_CMD_WRITE);
  assign BUF_FILL_OUT        = do_fill;
  // an erase keeps the buffer, so it may be filled before the erase
  assign BUF_CLEAR_OUT       = ~RESETN_IN | reen_wr |
                               (prog_end & (cur_cmd == bfl_pkg::BFL_CMD_WRITE)); // [RULE24]
  assign FLASH_PAGE_ADDR_OUT = page_reg;
  assign LOAD_DATA_OUT       = load_data_reg;
  assign LOAD_BLOCKED_OUT    = load_blk_reg;
  assign STORE_BLOCKED_OUT   = store_blk_reg;
  assign IRQ_BLOCK_OUT       = lk.irq_block;
  assign CORE_HALT_OUT       = halt_reg;
  // ready interrupt while store enable is clear
  assign READY_IRQ_OUT = ctrl_reg[`BFL_BIT_IRQ_EN] & GLOBAL_IRQ_EN_IN &
                         ~ctrl_reg[`BFL_BIT_STORE_EN]; // [RULE15]
  // fuses are inputs only, no write path from the core [RULE13]
  assign RESET_VECTOR_OUT = BOOT_RESET_FUSE_IN ? AW'(`BFL_APP_RESET_VEC)
                                               : BOOT_START_IN; // [RULE12]

  // apb read mux
  wire [7:0] ctrl_view = {ctrl_reg[7], busy_reg, 1'b0, ctrl_reg[4:0]};
  assign PRDATA_OUT  = ~(apb_acc & ~PWRITE_IN) ? 32'h00000000 :
                       hit_ctrl ? {24'h000000, ctrl_view} :
                       hit_lock ? {24'h000000, 2'b11, boot_lock_reg, app_lock_reg, 2'b11} :
                       hit_stat ? {28'h0000000, loading_reg, halt_reg, op_busy, armed} :
                       hit_core ? {16'h0000, load_data_reg} : 32'h00000000;
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = apb_acc & ~hit_any;
endmodule

// ===== bench/bfl_ctrl_sva.sv
`timescale 1ns/1ps
module bfl_ctrl_sva #(
  parameter int AW = 16
) (
  // clock, reset and apb
  input wire logic          MCLK_IN,
  input wire logic          RESETN_IN,
  input wire logic          PSEL_IN,
  input wire logic          PENABLE_IN,
  input wire logic          PWRITE_IN,
  input wire logic [11:0]   PADDR_IN,
  input wire logic [31:0]   PRDATA_OUT,
  input wire logic          PSLVERR_OUT,
  // core and flash side
  input wire logic          STORE_REQ_IN,
  input wire logic          LOAD_REQ_IN,
  input wire logic [15:0]   FLASH_RDATA_IN,
  input wire logic          GLOBAL_IRQ_EN_IN,
  input wire logic [15:0]   LOAD_DATA_OUT,
  input wire logic          LOAD_BLOCKED_OUT,
  input wire logic          STORE_BLOCKED_OUT,
  input wire logic          READY_IRQ_OUT,
  input wire logic          CORE_HALT_OUT,
  input wire logic          FLASH_ERASE_OUT,
  input wire logic          FLASH_WRITE_OUT,
  input wire logic          BUF_FILL_OUT,
  // fuses
  input wire logic          BOOT_RESET_FUSE_IN,
  input wire logic [AW-1:0] BOOT_START_IN,
  input wire logic [AW-1:0] RESET_VECTOR_OUT
);
  // shared decode; only the four word offsets are mapped
  wire acc   = PSEL_IN && PENABLE_IN;
  wire unmap = (PADDR_IN > 12'h00C) || (PADDR_IN[1:0] != 2'h0);
  wire stb   = FLASH_ERASE_OUT || FLASH_WRITE_OUT || BUF_FILL_OUT;
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (!RESETN_IN);
  a_unmapped_quiet: assert property (acc && unmap |-> PSLVERR_OUT && PRDATA_OUT == 32'h0)
    else $error("unmapped access not refused");
  a_reserved_zero: assert property (acc && !PWRITE_IN && PADDR_IN == 12'h000 |->
    PRDATA_OUT[5] == 1'b0 && PRDATA_OUT[31:8] == 24'h0) else $error("reserved bit not zero");
  a_reset_vector: assert property (RESET_VECTOR_OUT == (BOOT_RESET_FUSE_IN ? '0 : BOOT_START_IN))
    else $error("reset vector wrong");
  a_strobe_cause: assert property (stb |-> STORE_REQ_IN && $onehot({FLASH_ERASE_OUT,
    FLASH_WRITE_OUT, BUF_FILL_OUT})) else $error("flash strobe without store");
  a_blocked_quiet: assert property (STORE_BLOCKED_OUT |-> $past(STORE_REQ_IN) && !$past(stb))
    else $error("blocked store still strobed");
  a_load_result: assert property (LOAD_REQ_IN |=>
    LOAD_DATA_OUT == (LOAD_BLOCKED_OUT ? 16'hFFFF : $past(FLASH_RDATA_IN)))
    else $error("load data wrong");
  a_irq_gated: assert property (READY_IRQ_OUT |-> GLOBAL_IRQ_EN_IN)
    else $error("ready interrupt without global enable");
  a_halt_cause: assert property ($rose(CORE_HALT_OUT) |-> $past(FLASH_ERASE_OUT || FLASH_WRITE_OUT))
    else $error("halt without program start");
  c_halt: cover property ($rose(CORE_HALT_OUT));
  c_store_blocked: cover property (STORE_BLOCKED_OUT);
  c_load_blocked: cover property (LOAD_REQ_IN ##1 LOAD_BLOCKED_OUT);
endmodule
bind bfl_boot_lock_ctrl bfl_ctrl_sva #(.AW(AW)) i_sva (
  .MCLK_IN(MCLK_IN), .RESETN_IN(RESETN_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
  .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .STORE_REQ_IN(STORE_REQ_IN), .LOAD_REQ_IN(LOAD_REQ_IN), .FLASH_RDATA_IN(FLASH_RDATA_IN),
  .GLOBAL_IRQ_EN_IN(GLOBAL_IRQ_EN_IN), .LOAD_DATA_OUT(LOAD_DATA_OUT),
  .LOAD_BLOCKED_OUT(LOAD_BLOCKED_OUT), .STORE_BLOCKED_OUT(STORE_BLOCKED_OUT),
  .READY_IRQ_OUT(READY_IRQ_OUT), .CORE_HALT_OUT(CORE_HALT_OUT), .FLASH_ERASE_OUT(FLASH_ERASE_OUT),
  .FLASH_WRITE_OUT(FLASH_WRITE_OUT), .BUF_FILL_OUT(BUF_FILL_OUT),
  .BOOT_RESET_FUSE_IN(BOOT_RESET_FUSE_IN), .BOOT_START_IN(BOOT_START_IN),
  .RESET_VECTOR_OUT(RESET_VECTOR_OUT)
);

// ===== bench/bfl_core_model.sv
`timescale 1ns/1ps
module bfl_core_model (
  // clock
  input  wire logic   clk_in,
  // instruction side towards the block
  output logic        store_req_out,
  output logic        load_req_out,
  output logic [15:0] addr_out,
  output logic [15:0] rdata_out,
  output logic [7:0]  r0_out,
  // flash strobes from the block
  input  wire logic   fill_in,
  input  wire logic   erase_in,
  input  wire logic   write_in
);
  logic [2:0] seen_strobes;
  // quiet bus at time zero
  initial begin
    {store_req_out, load_req_out, r0_out} = '0;
    {addr_out, rdata_out} = 32'hFFFF0000;
  end
  // store: one-cycle request, strobes sampled mid-cycle while they stand
  task automatic store(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    store_req_out <= 1'b1; // issued at the next rising edge, whether or not the window is open
    addr_out <= a;
    r0_out <= d;
    @(negedge clk_in);
    seen_strobes = {fill_in, erase_in, write_in};
    @(posedge clk_in);
    store_req_out <= 1'b0;
    addr_out <= ~a; // stale address and data never look valid
    r0_out <= ~d;
    @(negedge clk_in);
  endtask
  // load: flash data only valid in the request cycle
  task automatic load(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_in);
    load_req_out <= 1'b1;
    addr_out <= a;
    rdata_out <= d;
    @(posedge clk_in);
    load_req_out <= 1'b0;
    addr_out <= ~a;
    rdata_out <= ~d;
    @(negedge clk_in);
  endtask
endmodule

// ===== bench/test_boot_flash_lock_and_rww_control.sv
`timescale 1ns/1ps
`include "bfl_params.svh"
module test_boot_flash_lock_and_rww_control;
  localparam logic [15:0] APP_A  = 16'h0100;
  localparam logic [15:0] BOOT_A = 16'h7100;
  localparam logic [15:0] EDGE_A = 16'h7000;
  logic        mclk, resetn, psel, penable, pwrite, pready, pslverr, e, store_req, load_req;
  logic        exec_boot, ivec_boot, gie, chip_erase, fuse, ld_blk, st_blk, irq_blk, rdy_irq;
  logic        halt, ers, wrt, fil, bclr;
  logic [7:0]  r0;
  logic [11:0] paddr;
  logic [15:0] faddr, frdata, ld_data, rvec, page;
  logic [31:0] pwdata, prdata, r;
  int          fails, total_checks, k, nclr;
  // 50 MHz clock
  always #10 mclk = ~mclk;
  // count buffer clears; a one-cycle pulse is too short for the tasks to catch
  always @(posedge mclk)
    if (resetn && bclr) nclr <= nclr + 1;
  bfl_boot_lock_ctrl #(.PROG_CYC(16'h0008)) i_dut (
    .MCLK_IN(mclk), .RESETN_IN(resetn), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .STORE_REQ_IN(store_req), .LOAD_REQ_IN(load_req),
    .FLASH_ADDR_IN(faddr), .FLASH_RDATA_IN(frdata), .LOCK_WDATA_IN(r0),
    .EXEC_IN_BOOT_IN(exec_boot), .IVEC_IN_BOOT_IN(ivec_boot), .GLOBAL_IRQ_EN_IN(gie),
    .LOAD_DATA_OUT(ld_data), .LOAD_BLOCKED_OUT(ld_blk), .STORE_BLOCKED_OUT(st_blk),
    .IRQ_BLOCK_OUT(irq_blk), .READY_IRQ_OUT(rdy_irq), .CORE_HALT_OUT(halt),
    .FLASH_ERASE_OUT(ers), .FLASH_WRITE_OUT(wrt), .BUF_FILL_OUT(fil), .BUF_CLEAR_OUT(bclr),
    .FLASH_PAGE_ADDR_OUT(page), .CHIP_ERASE_IN(chip_erase), .BOOT_RESET_FUSE_IN(fuse),
    .BOOT_START_IN(EDGE_A), .RWW_END_IN(EDGE_A), .RESET_VECTOR_OUT(rvec));
  bfl_core_model i_core (
    .clk_in(mclk), .store_req_out(store_req), .load_req_out(load_req), .addr_out(faddr),
    .rdata_out(frdata), .r0_out(r0), .fill_in(fil), .erase_in(ers), .write_in(wrt));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [32:0] got, input logic [32:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // one apb transfer, request held until pready is seen, bounded wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      check(32'h0, 32'h1, "apb answer timeout");
      complete_run();
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] x, input string what);
    apb(1'b0, a, 8'h00);
    check(r, {24'h000000, x}, what);
  endtask
  task automatic t_reset_map();
    rdchk(`BFL_ADDR_CTRL, 8'h00, "ctrl reset");
    rdchk(`BFL_ADDR_LOCK, 8'hFF, "locks reset");
    apb(1'b0, 12'h010, 8'h00);
    check({e, r}, 33'h100000000, "unmapped read");
    check(rvec, 16'h0000, "application reset vector");
    @(posedge mclk) fuse <= 1'b0;
    @(negedge mclk) check(rvec, EDGE_A, "boot reset vector");
    apb(1'b1, `BFL_ADDR_CTRL, 8'hFF);
    rdchk(`BFL_ADDR_CTRL, 8'h80, "bad pattern, reserved bits");
    apb(1'b1, `BFL_ADDR_CTRL, 8'h00);
  endtask
  task automatic t_window();
    apb(1'b1, `BFL_ADDR_CTRL, 8'h01);
    i_core.store(APP_A, 8'h00);
    check(i_core.seen_strobes, 3'b100, "fill in unlocked section");
    rdchk(`BFL_ADDR_CTRL, 8'h00, "store enable consumed");
    @(posedge mclk) gie <= 1'b1;
    apb(1'b1, `BFL_ADDR_CTRL, 8'h81);
    @(negedge mclk) check(rdy_irq, 1'b0, "no ready irq while armed");
    repeat (6) @(posedge mclk);
    i_core.store(APP_A, 8'h00);
    check(i_core.seen_strobes, 3'b000, "late store ignored");
    check(rdy_irq, 1'b1, "ready irq after window");
    @(posedge mclk) gie <= 1'b0;
    @(negedge mclk) check(rdy_irq, 1'b0, "ready irq needs global flag");
    apb(1'b1, `BFL_ADDR_CTRL, 8'h00);
  endtask
  task automatic t_rww();
    k = nclr;
    apb(1'b1, `BFL_ADDR_CTRL, 8'h03);
    i_core.store(APP_A, 8'h00);
    check(i_core.seen_strobes, 3'b010, "erase strobe");
    apb(1'b1, `BFL_ADDR_CTRL, 8'h11);
    rdchk(`BFL_ADDR_CTRL, 8'h43, "busy, re-enable ignored");
    i_core.load(APP_A, 16'h1234);
    check({ld_blk, ld_data}, 17'h1FFFF, "busy section load");
    repeat (10) @(posedge mclk);
    rdchk(`BFL_ADDR_CTRL, 8'h40, "busy stays after erase");
    check(nclr, k, "buffer kept after erase");
    apb(1'b1, `BFL_ADDR_CTRL, 8'h11);
    i_core.store(APP_A, 8'h00);
    rdchk(`BFL_ADDR_CTRL, 8'h00, "busy cleared");
    check(nclr, k + 1, "re-enable write clears buffer");
    i_core.load(APP_A, 16'h1234);
    check({ld_blk, ld_data}, 17'h01234, "section readable");
  endtask
  task automatic t_halt();
    apb(1'b1, `BFL_ADDR_CTRL, 8'h05);
    i_core.store(BOOT_A, 8'h00);
    check({i_core.seen_strobes, halt}, 4'b0011, "write halts core");
    rdchk(`BFL_ADDR_CTRL, 8'h05, "no busy for stalling section");
    repeat (10) @(posedge mclk);
    @(negedge mclk) check(halt, 1'b0, "halt released");
    check(nclr, k + 2, "buffer cleared after page write");
    check(page, BOOT_A, "page address latched");
  endtask
  task automatic t_locks();
    apb(1'b1, `BFL_ADDR_CTRL, 8'h09);
    i_core.store(APP_A, 8'hD3);
    rdchk(`BFL_ADDR_LOCK, 8'hD3, "locks programmed");
    apb(1'b1, `BFL_ADDR_CTRL, 8'h09);
    i_core.store(APP_A, 8'hFF);
    rdchk(`BFL_ADDR_LOCK, 8'hD3, "software cannot unprogram");
    apb(1'b1, `BFL_ADDR_CTRL, 8'h01);
    i_core.store(APP_A, 8'h00);
    check({i_core.seen_strobes, st_blk}, 4'b0001, "app store blocked");
    apb(1'b1, `BFL_ADDR_CTRL, 8'h01);
    i_core.store(BOOT_A, 8'h00);
    check({i_core.seen_strobes, st_blk}, 4'b1000, "boot store allowed");
    @(posedge mclk) exec_boot <= 1'b1;
    i_core.load(APP_A, 16'h5A5A);
    check({ld_blk, ld_data}, 17'h1FFFF, "boot reads app");
    @(posedge mclk) exec_boot <= 1'b0;
    i_core.load(BOOT_A, 16'hA5A5);
    check({ld_blk, ld_data}, 17'h1FFFF, "app reads boot");
    i_core.load(APP_A, 16'h3C3C);
    check({ld_blk, ld_data}, 17'h03C3C, "app reads app");
    for (k = 0; k < 4; k++) begin
      @(posedge mclk) {exec_boot, ivec_boot} <= k[1:0];
      @(negedge mclk) check(irq_blk, k[1] ^ k[0], "interrupt gating");
    end
    @(posedge mclk) chip_erase <= 1'b1;
    @(posedge mclk) chip_erase <= 1'b0;
    rdchk(`BFL_ADDR_LOCK, 8'hFF, "chip erase clears locks");
  endtask
  initial begin
    {mclk, resetn, psel, penable, pwrite, exec_boot, ivec_boot, gie, chip_erase} = '0;
    {paddr, pwdata} = '0;
    fuse = 1'b1;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    t_reset_map();
    t_window();
    t_rww();
    t_halt();
    t_locks();
    complete_run();
  end
endmodule
